/* File: vsrc_pkg.sv */
/*
  Constants and types shared by the velocity stop-ramp configuration block:
  object indexes, sub-entries, reset values, action codes and states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vsrc_pkg;

  // ----------------------------------------------------------------------
  // Object indexes and sub-entries
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_QSTOP_RAMP = 16'h604A;
  localparam logic [15:0] IDX_SPEED_UNIT = 16'h604C;
  localparam logic [15:0] IDX_QSTOP_ACT = 16'h605A;
  localparam logic [15:0] IDX_SHUTDOWN_ACT = 16'h605B;
  localparam logic [15:0] IDX_DISABLE_ACT = 16'h605C;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_ENTRY_COUNT = 8'h02;
  localparam logic [31:0] RST_QS_SPEED = 32'h00001388;
  localparam logic [15:0] RST_QS_TIME = 16'h0001;
  localparam logic [31:0] RST_UNIT_NUM = 32'h00000001;
  localparam logic [31:0] RST_UNIT_DEN = 32'h00000001;
  localparam logic [15:0] RST_ACTION = 16'h0001;

  // ----------------------------------------------------------------------
  // Action codes, mode code, divider length
  // ----------------------------------------------------------------------
  localparam logic [15:0] ACT_IMMEDIATE = 16'h0000;
  localparam logic [15:0] ACT_SLOW = 16'h0001;
  localparam logic [15:0] ACT_QUICK = 16'h0002;
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  localparam logic [6:0] DIV_STEPS = 7'h40;

  typedef enum logic [1:0] {
    STOP_NONE = 2'b00,
    STOP_NOW = 2'b01,
    STOP_SLOW = 2'b10,
    STOP_QUICK = 2'b11
  } vsrc_stop_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BRAKE = 2'b01
  } vsrc_state_t;

endpackage

/* File: vsrc_cvt_if.sv */
/*
  Handshake bundle between the top block and the speed unit converter.
  Assumes the controlling side pulses start only while busy is low.
*/
interface vsrc_cvt_if #(parameter int W = 32);
  logic start;
  logic signed [W-1:0] value;
  logic signed [W-1:0] num;
  logic signed [W-1:0] den;
  logic busy;
  logic done;
  logic div_zero;
  logic signed [W-1:0] result;

  modport conv (input start, value, num, den, output busy, done, div_zero, result);
  modport ctrl (output start, value, num, den, input busy, done, div_zero, result);
endinterface

/* File: vsrc_optreg.sv */
/*
  One stop-action code register that refuses reserved values.
  Assumes writes are single-cycle strobes from the object access port.
*/
module vsrc_optreg #(
  parameter logic [15:0] MAX_CODE = 16'h0001
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_wr, // Write strobe
  input wire logic [15:0] i_wdata, // Code to store
  output logic o_invalid, // Written value is reserved
  output logic [15:0] o_code // Stored code
);

  // Negative codes and codes above the limit are reserved
  assign o_invalid = i_wdata[15] || (i_wdata > MAX_CODE);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_code <= vsrc_pkg::RST_ACTION;
    end else if (i_wr && !o_invalid) begin // [R9]
      o_code <= i_wdata;
    end
  end

  keep_on_reject_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R9]
    (i_wr && o_invalid) |=> (o_code == $past(o_code)))
    else $error("reserved action code was stored");

  code_in_range_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R9]
    !o_code[15] && (o_code <= MAX_CODE))
    else $error("stored action code out of range");

endmodule // vsrc_optreg

/* File: vsrc_speedconv.sv */
/*
  Signed speed unit converter: result = value * num / den, truncated.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
module vsrc_speedconv (
  input wire logic i_clk_sys, // System clock
  input wire logic i_resetn, // Async reset, active low
  vsrc_cvt_if.conv cvt // Request and result bundle
);

  logic signed [63:0] product;
  logic [63:0] prod_mag;
  logic [31:0] den_mag;
  logic [32:0] rem_shift;
  logic rem_ge;
  logic [63:0] quo_ff;
  logic [32:0] rem_ff;
  logic [31:0] dmag_ff;
  logic neg_ff;
  logic [6:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic dz_ff;
  logic [31:0] res_ff;
  logic [31:0] quo_low;

  // --------------------------------------------------------------------
  // Operand magnitudes
  // --------------------------------------------------------------------
  assign product = cvt.value * cvt.num; // [R3]
  assign prod_mag = product[63] ? 64'(-product) : 64'(product);
  assign den_mag = cvt.den[31] ? 32'(-cvt.den) : 32'(cvt.den);
  assign rem_shift = {rem_ff[31:0], quo_ff[63]};
  assign rem_ge = rem_shift >= {1'b0, dmag_ff};
  assign quo_low = quo_ff[31:0];

  // Restoring division, one quotient bit a cycle: small area, 64 cycles
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      quo_ff <= 64'h0;
      rem_ff <= 33'h0;
      dmag_ff <= 32'h0;
      neg_ff <= 1'b0;
      cnt_ff <= 7'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      dz_ff <= 1'b0;
      res_ff <= 32'h0;
    end else begin
      done_ff <= 1'b0;
      if (cvt.start && !busy_ff) begin
        if (den_mag == 32'h0) begin
          dz_ff <= 1'b1;
          res_ff <= 32'h0;
          done_ff <= 1'b1;
        end else begin
          quo_ff <= prod_mag;
          rem_ff <= 33'h0;
          dmag_ff <= den_mag;
          neg_ff <= product[63] ^ cvt.den[31];
          cnt_ff <= vsrc_pkg::DIV_STEPS;
          busy_ff <= 1'b1;
        end
      end else if (busy_ff) begin
        rem_ff <= rem_ge ? 33'(rem_shift - {1'b0, dmag_ff}) : rem_shift;
        quo_ff <= {quo_ff[62:0], rem_ge};
        cnt_ff <= 7'(cnt_ff - 7'h01);
        if (cnt_ff == 7'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          dz_ff <= 1'b0;
          res_ff <= neg_ff ? 32'(-{quo_ff[30:0], rem_ge}) : {quo_ff[30:0], rem_ge};
        end
      end
    end
  end

  assign cvt.busy = busy_ff;
  assign cvt.done = done_ff;
  assign cvt.div_zero = dz_ff;
  assign cvt.result = res_ff;

  conv_bounded_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R3]
    (cvt.start && !busy_ff) |-> ##[1:66] done_ff)
    else $error("conversion did not finish in time");

  zero_den_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R3]
    (done_ff && dz_ff) |-> (res_ff == 32'h0))
    else $error("zero divisor gave nonzero result");

endmodule // vsrc_speedconv

/* File: vsrc_top.sv */
/*
  Velocity quick-stop ramp, speed unit factor and stop-action codes with
  the stop sequencer they steer. Objects are reached by index/sub-entry.
  Assumes the power state machine gives one-cycle transition pulses and a
  standstill level, and that ramps of other modes arrive as inputs.
*/
// Notes on behaviour
// R1: Velocity quick stop uses dedicated quick-stop ramp
// R2: Ramp is speed step over time step
// R3: Speed to rpm: times numerator, over denominator
// R4: Quick stop entry runs quick-stop action code
// R5: Quick codes: 0 now, 1 slow, 2 quick
// R6: Shutdown transition: 0 now, 1 slow ramp
// R7: Disable transition uses disable code, reset 1
// R8: Disable codes: 0 now, 1 slow, rest reserved
// R9: Reserved code writes refused, old code kept
module vsrc_top (
  input wire logic i_clk_sys, // System clock, 250 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_od_wr, // Object write strobe
  input wire logic i_od_rd, // Object read strobe
  input wire logic [15:0] i_od_index, // Object index
  input wire logic [7:0] i_od_subidx, // Object sub-entry
  input wire logic [31:0] i_od_wdata, // Write data, low bits used
  output logic o_od_ack, // Access answered, pulse
  output logic o_od_err, // Access refused, with ack
  output logic [31:0] o_od_rdata, // Read data, with ack
  input wire logic [7:0] i_mode, // Active operating mode
  input wire logic i_qs_enter, // Transition into Quick Stop, pulse
  input wire logic i_oe_to_rtso, // Operation enabled to Ready to switch on
  input wire logic i_oe_to_so, // Operation enabled to Switched on
  input wire logic i_standstill, // Motor is at rest
  input wire logic [31:0] i_slow_speed, // Mode slow-down ramp speed step
  input wire logic [15:0] i_slow_time, // Mode slow-down ramp time step
  input wire logic [31:0] i_mode_qs_speed, // Other modes quick ramp speed step
  input wire logic [15:0] i_mode_qs_time, // Other modes quick ramp time step
  input wire logic [31:0] i_speed_internal, // Internal speed value
  input wire logic i_speed_valid, // Convert this speed, pulse
  output logic [1:0] o_stop_kind, // Active stop action
  output logic [31:0] o_ramp_speed, // Ramp speed step in use
  output logic [15:0] o_ramp_time, // Ramp time step in use
  output logic o_sod_req, // Enter Switch on disabled, pulse
  output logic [31:0] o_speed_rpm, // Converted speed
  output logic o_rpm_valid, // Converted speed ready, pulse
  output logic o_rpm_div_zero // Last conversion had zero divisor
);

  // --------------------------------------------------------------------
  // Object decode
  // --------------------------------------------------------------------
  logic hit_ramp;
  logic hit_unit;
  logic hit_qsa;
  logic hit_sda;
  logic hit_dis;
  logic sub0;
  logic sub1;
  logic sub2;
  logic rec_hit;
  logic map_ok;
  logic wr_qs_speed;
  logic wr_qs_time;
  logic wr_num;
  logic wr_den;
  logic wr_qsa;
  logic wr_sda;
  logic wr_dis;
  logic qsa_bad;
  logic sda_bad;
  logic dis_bad;
  logic wr_refused;
  logic [31:0] rd_word;

  assign hit_ramp = i_od_index == vsrc_pkg::IDX_QSTOP_RAMP;
  assign hit_unit = i_od_index == vsrc_pkg::IDX_SPEED_UNIT;
  assign hit_qsa = i_od_index == vsrc_pkg::IDX_QSTOP_ACT;
  assign hit_sda = i_od_index == vsrc_pkg::IDX_SHUTDOWN_ACT;
  assign hit_dis = i_od_index == vsrc_pkg::IDX_DISABLE_ACT;
  assign sub0 = i_od_subidx == vsrc_pkg::SUB_COUNT;
  assign sub1 = i_od_subidx == vsrc_pkg::SUB_FIRST;
  assign sub2 = i_od_subidx == vsrc_pkg::SUB_SECOND;
  assign rec_hit = hit_ramp || hit_unit;
  assign map_ok = (rec_hit && (sub0 || sub1 || sub2)) || ((hit_qsa || hit_sda || hit_dis) && sub0);

  assign wr_qs_speed = i_od_wr && hit_ramp && sub1; // [R2]
  assign wr_qs_time = i_od_wr && hit_ramp && sub2; // [R2]
  assign wr_num = i_od_wr && hit_unit && sub1;
  assign wr_den = i_od_wr && hit_unit && sub2;
  assign wr_qsa = i_od_wr && hit_qsa && sub0;
  assign wr_sda = i_od_wr && hit_sda && sub0;
  assign wr_dis = i_od_wr && hit_dis && sub0;
  // Entry counts are read-only; reserved codes are refused
  assign wr_refused = !map_ok || (rec_hit && sub0) || (wr_qsa && qsa_bad) ||
                      (wr_sda && sda_bad) || (wr_dis && dis_bad); // [R9]

  // --------------------------------------------------------------------
  // Stored objects
  // --------------------------------------------------------------------
  logic [31:0] qs_speed_ff;
  logic [15:0] qs_time_ff;
  logic [31:0] unit_num_ff;
  logic [31:0] unit_den_ff;
  logic [15:0] qsa_code;
  logic [15:0] sda_code;
  logic [15:0] dis_code;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      qs_speed_ff <= vsrc_pkg::RST_QS_SPEED;
      qs_time_ff <= vsrc_pkg::RST_QS_TIME;
      unit_num_ff <= vsrc_pkg::RST_UNIT_NUM;
      unit_den_ff <= vsrc_pkg::RST_UNIT_DEN;
    end else begin
      if (wr_qs_speed) qs_speed_ff <= i_od_wdata;
      if (wr_qs_time) qs_time_ff <= i_od_wdata[15:0];
      if (wr_num) unit_num_ff <= i_od_wdata;
      if (wr_den) unit_den_ff <= i_od_wdata;
    end
  end

  vsrc_optreg #(.MAX_CODE(vsrc_pkg::ACT_QUICK)) u_qsa (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_wr(wr_qsa),
    .i_wdata(i_od_wdata[15:0]),
    .o_invalid(qsa_bad),
    .o_code(qsa_code)
  );

  vsrc_optreg #(.MAX_CODE(vsrc_pkg::ACT_SLOW)) u_sda (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_wr(wr_sda),
    .i_wdata(i_od_wdata[15:0]),
    .o_invalid(sda_bad),
    .o_code(sda_code)
  );

  vsrc_optreg #(.MAX_CODE(vsrc_pkg::ACT_SLOW)) u_dis ( // [R8]
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_wr(wr_dis),
    .i_wdata(i_od_wdata[15:0]),
    .o_invalid(dis_bad),
    .o_code(dis_code)
  );

  // Narrow objects sit in the low bits, upper bits read zero
  assign rd_word = !map_ok ? 32'h0 :
                   (rec_hit && sub0) ? {24'h0, vsrc_pkg::RST_ENTRY_COUNT} :
                   (hit_ramp && sub1) ? qs_speed_ff :
                   hit_ramp ? {16'h0, qs_time_ff} :
                   (hit_unit && sub1) ? unit_num_ff :
                   hit_unit ? unit_den_ff :
                   hit_qsa ? {16'h0, qsa_code} :
                   hit_sda ? {16'h0, sda_code} : {16'h0, dis_code};

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_od_ack <= 1'b0;
      o_od_err <= 1'b0;
      o_od_rdata <= 32'h0;
    end else begin
      o_od_ack <= i_od_wr || i_od_rd;
      o_od_err <= i_od_wr ? wr_refused : (i_od_rd && !map_ok);
      o_od_rdata <= (i_od_rd && !i_od_wr) ? rd_word : 32'h0;
    end
  end

  // --------------------------------------------------------------------
  // Stop sequencer
  // --------------------------------------------------------------------
  vsrc_pkg::vsrc_state_t state_ff;
  vsrc_pkg::vsrc_state_t nxt_state;
  vsrc_pkg::vsrc_stop_t sel_kind;
  logic ev_any;
  logic [15:0] sel_code;
  logic vel_mode;
  logic [31:0] sel_speed;
  logic [15:0] sel_time;
  logic brake_end;

  assign ev_any = (state_ff == vsrc_pkg::ST_IDLE) && (i_qs_enter || i_oe_to_rtso || i_oe_to_so);
  // Quick Stop outranks shutdown, shutdown outranks disable
  assign sel_code = i_qs_enter ? qsa_code : // [R4]
                    i_oe_to_rtso ? sda_code : dis_code; // [R6] [R7]
  assign sel_kind = (sel_code == vsrc_pkg::ACT_IMMEDIATE) ? vsrc_pkg::STOP_NOW : // [R5] [R8]
                    (sel_code == vsrc_pkg::ACT_SLOW) ? vsrc_pkg::STOP_SLOW :
                    vsrc_pkg::STOP_QUICK;
  assign vel_mode = i_mode == vsrc_pkg::MODE_VELOCITY;
  assign sel_speed = (sel_kind != vsrc_pkg::STOP_QUICK) ? i_slow_speed :
                     vel_mode ? qs_speed_ff : i_mode_qs_speed; // [R1] [R2]
  assign sel_time = (sel_kind != vsrc_pkg::STOP_QUICK) ? i_slow_time :
                    vel_mode ? qs_time_ff : i_mode_qs_time; // [R1] [R2]
  assign brake_end = (state_ff == vsrc_pkg::ST_BRAKE) && i_standstill;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vsrc_pkg::ST_IDLE: begin
        if (ev_any) nxt_state = vsrc_pkg::ST_BRAKE; // [R4]
      end
      vsrc_pkg::ST_BRAKE: begin
        if (i_standstill) nxt_state = vsrc_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = vsrc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= vsrc_pkg::ST_IDLE;
      o_stop_kind <= vsrc_pkg::STOP_NONE;
      o_ramp_speed <= 32'h0;
      o_ramp_time <= 16'h0;
      o_sod_req <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Ramp kinds end in Switch on disabled; immediate stop does not
      o_sod_req <= brake_end && (o_stop_kind != vsrc_pkg::STOP_NOW); // [R5] [R6] [R8]
      if (ev_any) begin
        o_stop_kind <= sel_kind;
        o_ramp_speed <= sel_speed;
        o_ramp_time <= sel_time;
      end else if (brake_end) begin
        o_stop_kind <= vsrc_pkg::STOP_NONE;
      end
    end
  end

  // --------------------------------------------------------------------
  // Speed unit conversion
  // --------------------------------------------------------------------
  vsrc_cvt_if #(.W(32)) cvt ();

  // Speeds offered while a division runs are dropped, not queued
  assign cvt.start = i_speed_valid && !cvt.busy; // [R3]
  assign cvt.value = i_speed_internal;
  assign cvt.num = unit_num_ff;
  assign cvt.den = unit_den_ff;

  vsrc_speedconv u_conv (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .cvt(cvt)
  );

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_speed_rpm <= 32'h0;
      o_rpm_valid <= 1'b0;
      o_rpm_div_zero <= 1'b0;
    end else begin
      o_rpm_valid <= cvt.done;
      if (cvt.done) begin
        o_speed_rpm <= cvt.result;
        o_rpm_div_zero <= cvt.div_zero;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic seen_ff;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) seen_ff <= 1'b0;
    else seen_ff <= 1'b1;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence qs_taken;
    (state_ff == vsrc_pkg::ST_IDLE) && i_qs_enter;
  endsequence

  sequence dis_taken;
    (state_ff == vsrc_pkg::ST_IDLE) && i_oe_to_so && !i_qs_enter && !i_oe_to_rtso;
  endsequence

  vel_qs_ramp_a: assert property (qs_taken ##0 (vel_mode && qsa_code == vsrc_pkg::ACT_QUICK) // [R1]
    |=> (o_ramp_speed == $past(qs_speed_ff)) && (o_ramp_time == $past(qs_time_ff)))
    else $error("velocity quick stop did not use its own ramp");
  ramp_write_a: assert property ((wr_qs_speed ##1 !wr_qs_speed) // [R2]
    |-> (qs_speed_ff == $past(i_od_wdata)))
    else $error("ramp speed step not stored");
  qs_brake_a: assert property (qs_taken |=> (state_ff == vsrc_pkg::ST_BRAKE)) // [R4]
    else $error("quick stop entry not acted on");
  qs_code_a: assert property (qs_taken ##0 (qsa_code == vsrc_pkg::ACT_IMMEDIATE) // [R5]
    |=> (o_stop_kind == vsrc_pkg::STOP_NOW))
    else $error("quick stop code 0 not immediate");
  shutdown_slow_a: assert property (((state_ff == vsrc_pkg::ST_IDLE) && i_oe_to_rtso && // [R6]
    !i_qs_enter && sda_code == vsrc_pkg::ACT_SLOW) |=> (o_stop_kind == vsrc_pkg::STOP_SLOW))
    else $error("shutdown code 1 not slow ramp");
  disable_reset_a: assert property (!seen_ff |-> (dis_code == vsrc_pkg::RST_ACTION)) // [R7]
    else $error("disable code reset value wrong");
  disable_now_a: assert property (dis_taken ##0 (dis_code == vsrc_pkg::ACT_IMMEDIATE) // [R8]
    |=> (o_stop_kind == vsrc_pkg::STOP_NOW))
    else $error("disable code 0 not immediate");
  sod_after_a: assert property ((brake_end && o_stop_kind == vsrc_pkg::STOP_SLOW) // [R5]
    |=> o_sod_req ##1 !o_sod_req)
    else $error("slow ramp did not end in switch on disabled");
  ack_next_a: assert property ((i_od_wr || i_od_rd) |=> o_od_ack)
    else $error("object access not answered");

endmodule // vsrc_top

/* File: vsrc_master.sv */
/*
  Fieldbus master model: issues object reads and writes on the port.
  Assumes the answer comes with the taking edge or at most three edges after it.
*/
module vsrc_master (
  input wire logic i_clk_sys, // System clock
  input wire logic i_ack, // Access answered
  input wire logic i_err, // Access refused
  input wire logic [31:0] i_rdata, // Read data
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic [15:0] o_index, // Object index
  output logic [7:0] o_subidx, // Sub-entry
  output logic [31:0] o_wdata // Write data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_index = 16'h0000;
    o_subidx = 8'h00;
    o_wdata = 32'h00000000;
  end

  // Released index, sub-entry and data lines show inverted values so stale data never looks valid; strobes drop low
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] data, output logic err, output logic [31:0] rd, output logic hung);
    int n;
    hung = 1'b1;
    err = 1'b1;
    rd = 32'h00000000;
    @(posedge i_clk_sys);
    o_wr <= w;
    o_rd <= !w;
    o_index <= idx;
    o_subidx <= sub;
    o_wdata <= data;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_index <= ~idx;
    o_subidx <= ~sub;
    o_wdata <= ~data;
    for (n = 0; n < 4 && hung; n++) begin
      #1;
      if (i_ack === 1'b1) begin
        hung = 1'b0;
        err = i_err;
        rd = i_rdata;
      end else @(posedge i_clk_sys);
    end
  endtask
endmodule // vsrc_master

/* File: vsrc_bench.sv */
/*
  Self-checking bench for the stop-ramp configuration block.
  Assumes the master model drives the object port.
*/
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module vsrc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_resetn, wr, rd, ack, err, qs, rtso, so, stand, sval;
  logic [15:0] idx;
  logic [7:0] sub, mode;
  logic [31:0] wdata, rdata, speed;
  logic [1:0] kind;
  logic [31:0] rsp, rpm;
  logic [15:0] rtm;
  logic sod, rpm_v, dz;
  int num_errors = 0;
  int check_count = 0;

  vsrc_master master (.i_clk_sys(i_clk_sys), .i_ack(ack), .i_err(err), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_index(idx), .o_subidx(sub), .o_wdata(wdata));
  vsrc_top uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_od_wr(wr), .i_od_rd(rd),
    .i_od_index(idx), .i_od_subidx(sub), .i_od_wdata(wdata), .o_od_ack(ack),
    .o_od_err(err), .o_od_rdata(rdata), .i_mode(mode), .i_qs_enter(qs),
    .i_oe_to_rtso(rtso), .i_oe_to_so(so), .i_standstill(stand),
    .i_slow_speed(32'h00000123), .i_slow_time(16'h0007),
    .i_mode_qs_speed(32'h00000456), .i_mode_qs_time(16'h0009),
    .i_speed_internal(speed), .i_speed_valid(sval), .o_stop_kind(kind),
    .o_ramp_speed(rsp), .o_ramp_time(rtm), .o_sod_req(sod), .o_speed_rpm(rpm),
    .o_rpm_valid(rpm_v), .o_rpm_div_zero(dz));

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  task automatic test_done();
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic e);
    logic er, hung;
    logic [31:0] got;
    master.access(w, i, s, d, er, got, hung);
    if (hung) begin
      num_errors++;
      test_done();
    end
    `CHK("od_err", e, er)
    if (!w) `CHK("od_rdata", d, got)
  endtask

  task automatic stop_seq(input int ev, input logic [7:0] m, input logic [1:0] k,
    input logic [31:0] sp, input logic [15:0] tm, input logic sd);
    @(posedge i_clk_sys);
    mode <= m;
    qs <= (ev == 0);
    rtso <= (ev == 1);
    so <= (ev == 2);
    @(posedge i_clk_sys);
    {qs, rtso, so} <= 3'b000;
    #1;
    `CHK("stop_kind", k, kind)
    if (k != 2'b01) `CHK("ramp_speed", sp, rsp)
    if (k != 2'b01) `CHK("ramp_time", tm, rtm)
    repeat (3) @(posedge i_clk_sys);
    stand <= 1'b1;
    @(posedge i_clk_sys);
    stand <= 1'b0;
    #1;
    `CHK("stop_kind_end", 2'b00, kind)
    `CHK("sod_req", sd, sod)
    @(posedge i_clk_sys);
    #1;
    `CHK("sod_req_end", 1'b0, sod)
  endtask

  // Latency counts edges after the taking edge up to the one that raises valid
  task automatic convert(input logic [31:0] v, input logic [31:0] e, input logic z,
    input int lat);
    int n;
    @(posedge i_clk_sys);
    speed <= v;
    sval <= 1'b1;
    @(posedge i_clk_sys);
    sval <= 1'b0;
    n = 0;
    while (n < 100 && rpm_v !== 1'b1) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (rpm_v !== 1'b1) begin
      num_errors++;
      test_done();
    end
    `CHK("rpm_latency", lat, n)
    `CHK("speed_rpm", e, rpm)
    `CHK("rpm_div_zero", z, dz)
    @(posedge i_clk_sys);
    #1;
    `CHK("rpm_valid_end", 1'b0, rpm_v)
  endtask

  task automatic check_reset_values();
    `CHK("kind_rst", 2'b00, kind)
    `CHK("sod_rst", 1'b0, sod)
    `CHK("rpm_rst", 32'h00000000, rpm)
    `CHK("dz_rst", 1'b0, dz)
    obj(1'b0, 16'h604A, 8'h00, 32'h00000002, 1'b0);
    obj(1'b0, 16'h604A, 8'h01, 32'h00001388, 1'b0);
    obj(1'b0, 16'h604A, 8'h02, 32'h00000001, 1'b0);
    obj(1'b0, 16'h604C, 8'h00, 32'h00000002, 1'b0);
    obj(1'b0, 16'h604C, 8'h01, 32'h00000001, 1'b0);
    obj(1'b0, 16'h604C, 8'h02, 32'h00000001, 1'b0);
    obj(1'b0, 16'h605A, 8'h00, 32'h00000001, 1'b0);
    obj(1'b0, 16'h605B, 8'h00, 32'h00000001, 1'b0);
    obj(1'b0, 16'h605C, 8'h00, 32'h00000001, 1'b0);
  endtask

  task automatic check_objects();
    obj(1'b1, 16'h604A, 8'h01, 32'h00002000, 1'b0);
    obj(1'b1, 16'h604A, 8'h02, 32'hABCD0005, 1'b0);
    obj(1'b0, 16'h604A, 8'h01, 32'h00002000, 1'b0);
    obj(1'b0, 16'h604A, 8'h02, 32'h00000005, 1'b0);
    obj(1'b1, 16'h604A, 8'h00, 32'h00000007, 1'b1);
    obj(1'b0, 16'h604A, 8'h03, 32'h00000000, 1'b1);
    obj(1'b1, 16'h605A, 8'h00, 32'h00000002, 1'b0);
    obj(1'b1, 16'h605A, 8'h00, 32'h00000003, 1'b1);
    obj(1'b0, 16'h605A, 8'h00, 32'h00000002, 1'b0);
    obj(1'b1, 16'h605B, 8'h00, 32'h00000002, 1'b1);
    obj(1'b0, 16'h605B, 8'h00, 32'h00000001, 1'b0);
    obj(1'b1, 16'h605C, 8'h00, 32'h0000FFFF, 1'b1);
    obj(1'b0, 16'h605C, 8'h00, 32'h00000001, 1'b0);
  endtask

  task automatic check_stops();
    stop_seq(0, 8'h02, 2'b11, 32'h00002000, 16'h0005, 1'b1);
    stop_seq(0, 8'h03, 2'b11, 32'h00000456, 16'h0009, 1'b1);
    stop_seq(1, 8'h02, 2'b10, 32'h00000123, 16'h0007, 1'b1);
    stop_seq(2, 8'h02, 2'b10, 32'h00000123, 16'h0007, 1'b1);
    obj(1'b1, 16'h605C, 8'h00, 32'h00000000, 1'b0);
    stop_seq(2, 8'h02, 2'b01, 32'h00000000, 16'h0000, 1'b0);
    obj(1'b1, 16'h605A, 8'h00, 32'h00000000, 1'b0);
    stop_seq(0, 8'h02, 2'b01, 32'h00000000, 16'h0000, 1'b0);
    obj(1'b1, 16'h605A, 8'h00, 32'h00000001, 1'b0);
    stop_seq(0, 8'h02, 2'b10, 32'h00000123, 16'h0007, 1'b1);
    obj(1'b1, 16'h605B, 8'h00, 32'h00000000, 1'b0);
    stop_seq(1, 8'h02, 2'b01, 32'h00000000, 16'h0000, 1'b0);
  endtask

  task automatic check_convert();
    convert(32'h00001234, 32'h00001234, 1'b0, 65);
    obj(1'b1, 16'h604C, 8'h01, 32'h0000003C, 1'b0);
    obj(1'b1, 16'h604C, 8'h02, 32'h00000007, 1'b0);
    convert(32'hFFFFFF9C, 32'hFFFFFCA7, 1'b0, 65);
    obj(1'b1, 16'h604C, 8'h02, 32'h00000000, 1'b0);
    convert(32'h00000005, 32'h00000000, 1'b1, 1);
  endtask

  initial begin
    i_resetn = 1'b0;
    {qs, rtso, so, stand, sval} = 5'b00000;
    mode = 8'h02;
    speed = 32'h00000000;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    check_reset_values();
    check_objects();
    check_stops();
    check_convert();
    // Second reset in mid-run: every stored object must return to its reset value
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    check_reset_values();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    num_errors++;
    test_done();
  end
endmodule // vsrc_bench
